// ===== csb_defs.svh
`ifndef CSB_DEFS_SVH
`define CSB_DEFS_SVH

// ****************************************************************
// status word field positions
// ****************************************************************
`define CSB_RP_HI 15
`define CSB_RP_LO 11
`define CSB_DP_HI 10
`define CSB_DP_LO 8
`define CSB_CCR_HI 7
`define CSB_CCR_LO 0

// ****************************************************************
// condition code bit positions inside the low byte
// ****************************************************************
`define CSB_CCR_H 7
`define CSB_CCR_I 6
`define CSB_CCR_IL1 5
`define CSB_CCR_IL0 4
`define CSB_CCR_N 3
`define CSB_CCR_Z 2
`define CSB_CCR_V 1
`define CSB_CCR_C 0

// ****************************************************************
// reset values
// ****************************************************************
`define CSB_RST_RP 5'h00
`define CSB_RST_DP 3'h0
`define CSB_RST_IE 1'h0
`define CSB_RST_IL 2'h3
`define CSB_RST_FLAGS 5'h00

// ****************************************************************
// address map constants
// ****************************************************************
`define CSB_GPR_BASE_BIT 8
`define CSB_WORD_STEP 16'h0001
`define CSB_PUSH_SPAN 16'h0002

`endif

// ===== csb_pkg.sv
package csb_pkg;

    // operation class that drives the flag update
    typedef enum logic [2:0]
    {
        CSB_OP_ADD,
        CSB_OP_SUB,
        CSB_OP_SHL,
        CSB_OP_SHR,
        CSB_OP_LOGIC
    } csb_alu_op_type;

    // byte sequencer states for 16-bit memory traffic
    typedef enum logic [2:0]
    {
        CSB_SEQ_IDLE,
        CSB_SEQ_WR_HI,
        CSB_SEQ_WR_LO,
        CSB_SEQ_RD_HI,
        CSB_SEQ_RD_LO,
        CSB_SEQ_RD_DONE
    } csb_seq_type;

endpackage

// ===== csb_flag_unit.sv
`timescale 1ns/1ns
`default_nettype none

module csb_flag_unit
    import csb_pkg::*;
(
    input wire csb_alu_op_type op, // operation class
    input wire logic [7:0] opa, // first operand
    input wire logic [7:0] opb, // second operand
    input wire logic cin, // carry or borrow in
    input wire logic h_old, // half carry before
    input wire logic c_old, // carry before
    output logic [7:0] result, // byte result
    output logic h_new, // half carry
    output logic n_new, // negative
    output logic z_new, // zero
    output logic v_new, // overflow
    output logic c_new // carry
);

    // ****************************************************************
    // arithmetic paths
    // ****************************************************************
    wire logic [8:0] sum9;
    wire logic [8:0] dif9;
    wire logic [4:0] sum_nib;
    wire logic [4:0] dif_nib;
    assign sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
    assign dif9 = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
    assign sum_nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    assign dif_nib = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};

    // flag selection per operation class
    always_comb
    begin
        result = opa;
        h_new = h_old;
        v_new = 1'b0;
        c_new = c_old;
        case (op)
            CSB_OP_ADD:
            begin
                result = sum9[7:0];
                h_new = sum_nib[4];
                c_new = sum9[8];
                v_new = (opa[7] == opb[7]) && (sum9[7] != opa[7]);
            end
            CSB_OP_SUB:
            begin
                result = dif9[7:0];
                h_new = dif_nib[4];
                c_new = dif9[8];
                v_new = (opa[7] != opb[7]) && (dif9[7] != opa[7]);
            end
            CSB_OP_SHL:
            begin
                result = {opa[6:0], cin};
                c_new = opa[7];
            end
            CSB_OP_SHR:
            begin
                result = {cin, opa[7:1]};
                c_new = opa[0];
            end
            CSB_OP_LOGIC:
            begin
                result = opb;
            end
            default:
            begin
                result = opa;
            end
        endcase
        n_new = result[7];
        z_new = (result == 8'h00);
    end

endmodule
`default_nettype wire

// ===== csb_addr_map.sv
`timescale 1ns/1ns
`default_nettype none

module csb_addr_map
(
    input wire logic [2:0] dp, // direct bank select
    input wire logic [4:0] rp, // register bank pointer
    input wire logic [7:0] dir_operand, // short direct operand
    input wire logic [2:0] reg_sel, // low opcode bits
    output logic [15:0] dir_addr, // relocated direct address
    output logic [15:0] gpr_addr // register bank address
);

    // ****************************************************************
    // direct and register bank translation
    // ****************************************************************
    wire logic [3:0] dp_window;
    assign dp_window = {1'b0, dp} + 4'h1;

    // low half fixed, high half moved in 80h steps
    assign dir_addr = dir_operand[7] ?
        {5'h00, dp_window, dir_operand[6:0]} :
        {8'h00, dir_operand};

    // bank base plus register index above 0100h
    assign gpr_addr = {7'h00, 1'b1, rp, reg_sel};

endmodule
`default_nettype wire

// ===== csb_status_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "csb_defs.svh"

module csb_status_core
    import csb_pkg::*;
(
    input wire logic clk, // machine clock
    input wire logic rst_n, // async reset, low
    input wire logic psw_wr_en, // whole status word write
    input wire logic [15:0] psw_wr_data, // status word data
    output logic [15:0] psw_rd_data, // status word readback
    input wire logic mirror_wr_en, // pointer mirror write
    input wire logic [7:0] mirror_wr_data, // mirror byte data
    output logic [7:0] mirror_rd_data, // mirror byte readback
    input wire logic flag_upd_en, // load result flags
    input wire csb_alu_op_type alu_op, // operation class
    input wire logic [7:0] alu_a, // first operand
    input wire logic [7:0] alu_b, // second operand
    input wire logic alu_cin, // carry or borrow in
    output logic [7:0] alu_result_q, // registered result
    input wire logic ie_set, // enable set instruction
    input wire logic ie_clr, // enable clear instruction
    input wire logic irq_req, // peripheral request
    input wire logic [1:0] irq_level, // request programmed level
    input wire logic [15:0] sp_in, // current stack pointer
    output logic irq_accept, // accept pulse
    input wire logic [7:0] dir_operand, // direct operand
    input wire logic [2:0] reg_sel, // register index
    output logic [15:0] dir_addr_q, // mapped direct address
    output logic [15:0] gpr_addr_q, // mapped register address
    input wire logic word_wr_req, // 16-bit write request
    input wire logic word_rd_req, // 16-bit read request
    input wire logic [15:0] word_addr, // word base address
    input wire logic [15:0] word_wdata, // word write data
    output logic [15:0] word_rdata, // assembled read word
    output logic word_rd_valid, // read word ready pulse
    output logic word_busy, // sequencer busy
    output logic [15:0] mem_addr, // byte address to ram
    output logic [7:0] mem_wdata, // byte write data
    output logic mem_we, // byte write strobe
    output logic mem_re, // byte read strobe
    input wire logic [7:0] mem_rdata, // byte read data, next cycle
    input wire logic opnd_valid, // instruction byte strobe
    input wire logic [7:0] opnd_byte, // instruction byte
    output logic [15:0] opnd_word, // assembled operand
    output logic opnd_word_valid // operand ready pulse
);

    // ****************************************************************
    // status word registers
    // ****************************************************************
    logic [4:0] rp_reg;
    logic [2:0] dp_reg;
    logic ie_reg;
    logic [1:0] il_reg;
    logic h_reg;
    logic n_reg;
    logic z_reg;
    logic v_reg;
    logic c_reg;
    logic [7:0] ccr_byte;

    // flag unit results
    wire logic [7:0] fu_result;
    wire logic fu_h;
    wire logic fu_n;
    wire logic fu_z;
    wire logic fu_v;
    wire logic fu_c;

    // address map results
    wire logic [15:0] map_dir;
    wire logic [15:0] map_gpr;

    // sequencer state
    csb_seq_type seq_reg;
    csb_seq_type seq_next;
    logic [15:0] seq_addr_reg;
    logic [7:0] seq_lo_reg;
    logic [7:0] rd_hi_reg;

    // operand assembly
    logic opnd_hi_seen_reg;
    logic [7:0] opnd_hi_reg;

    // condition byte assembled from its bits
    always_comb
    begin
        ccr_byte = 8'h00;
        ccr_byte[`CSB_CCR_H] = h_reg;
        ccr_byte[`CSB_CCR_I] = ie_reg;
        ccr_byte[`CSB_CCR_IL1] = il_reg[1];
        ccr_byte[`CSB_CCR_IL0] = il_reg[0];
        ccr_byte[`CSB_CCR_N] = n_reg;
        ccr_byte[`CSB_CCR_Z] = z_reg;
        ccr_byte[`CSB_CCR_V] = v_reg;
        ccr_byte[`CSB_CCR_C] = c_reg;
    end

    // readback straight from the field registers
    assign psw_rd_data = {rp_reg, dp_reg, ccr_byte};
    assign mirror_rd_data = {rp_reg, dp_reg};

    // ****************************************************************
    // submodules
    // ****************************************************************
    csb_flag_unit u_flags
    (
        .op(alu_op),
        .opa(alu_a),
        .opb(alu_b),
        .cin(alu_cin),
        .h_old(h_reg),
        .c_old(c_reg),
        .result(fu_result),
        .h_new(fu_h),
        .n_new(fu_n),
        .z_new(fu_z),
        .v_new(fu_v),
        .c_new(fu_c)
    );

    csb_addr_map u_map
    (
        .dp(dp_reg),
        .rp(rp_reg),
        .dir_operand(dir_operand),
        .reg_sel(reg_sel),
        .dir_addr(map_dir),
        .gpr_addr(map_gpr)
    );

    // ****************************************************************
    // interrupt acceptance
    // ****************************************************************
    wire logic seq_idle;
    wire logic irq_take;
    assign seq_idle = (seq_reg == CSB_SEQ_IDLE);
    // lower number is higher priority, 11 never beats 11
    assign irq_take = irq_req && ie_reg && (irq_level < il_reg)
        && seq_idle && !word_wr_req && !word_rd_req;

    // pointer fields: whole word, then mirror byte
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rp_reg <= `CSB_RST_RP;
            dp_reg <= `CSB_RST_DP;
        end
        else if (psw_wr_en)
        begin
            rp_reg <= psw_wr_data[`CSB_RP_HI:`CSB_RP_LO];
            dp_reg <= psw_wr_data[`CSB_DP_HI:`CSB_DP_LO];
        end
        else if (mirror_wr_en)
        begin
            rp_reg <= mirror_wr_data[7:3];
            dp_reg <= mirror_wr_data[2:0];
        end
    end

    // enable flag and current level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ie_reg <= `CSB_RST_IE;
            il_reg <= `CSB_RST_IL;
        end
        else if (psw_wr_en)
        begin
            ie_reg <= psw_wr_data[`CSB_CCR_I];
            il_reg <= psw_wr_data[`CSB_CCR_IL1:`CSB_CCR_IL0];
        end
        else
        begin
            if (ie_set)
                ie_reg <= 1'b1;
            else if (ie_clr)
                ie_reg <= 1'b0;
            if (irq_take)
                il_reg <= irq_level;
        end
    end

    // result flags
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {h_reg, n_reg, z_reg, v_reg, c_reg} <= `CSB_RST_FLAGS;
            alu_result_q <= 8'h00;
        end
        else if (psw_wr_en)
        begin
            h_reg <= psw_wr_data[`CSB_CCR_H];
            n_reg <= psw_wr_data[`CSB_CCR_N];
            z_reg <= psw_wr_data[`CSB_CCR_Z];
            v_reg <= psw_wr_data[`CSB_CCR_V];
            c_reg <= psw_wr_data[`CSB_CCR_C];
        end
        else if (flag_upd_en)
        begin
            h_reg <= fu_h;
            n_reg <= fu_n;
            z_reg <= fu_z;
            v_reg <= fu_v;
            c_reg <= fu_c;
            alu_result_q <= fu_result;
        end
    end

    // registered address mapping outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dir_addr_q <= 16'h0000;
            gpr_addr_q <= 16'h0000;
        end
        else
        begin
            dir_addr_q <= map_dir;
            gpr_addr_q <= map_gpr;
        end
    end

    // ****************************************************************
    // 16-bit memory sequencer, high byte at lower address
    // ****************************************************************
    always_comb
    begin
        seq_next = seq_reg;
        case (seq_reg)
            CSB_SEQ_IDLE:
            begin
                if (word_wr_req || irq_take)
                    seq_next = CSB_SEQ_WR_HI;
                else if (word_rd_req)
                    seq_next = CSB_SEQ_RD_HI;
            end
            CSB_SEQ_WR_HI: seq_next = CSB_SEQ_WR_LO;
            CSB_SEQ_WR_LO: seq_next = CSB_SEQ_IDLE;
            CSB_SEQ_RD_HI: seq_next = CSB_SEQ_RD_LO;
            CSB_SEQ_RD_LO: seq_next = CSB_SEQ_RD_DONE;
            CSB_SEQ_RD_DONE: seq_next = CSB_SEQ_IDLE;
            default: seq_next = CSB_SEQ_IDLE;
        endcase
    end

    // stack push lands two below the pointer, high byte first
    wire logic [15:0] push_base;
    assign push_base = sp_in - `CSB_PUSH_SPAN;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            seq_reg <= CSB_SEQ_IDLE;
        else
            seq_reg <= seq_next;
    end

    // byte strobes and addresses
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
            mem_we <= 1'b0;
            mem_re <= 1'b0;
            seq_addr_reg <= 16'h0000;
            seq_lo_reg <= 8'h00;
            rd_hi_reg <= 8'h00;
            word_rdata <= 16'h0000;
            word_rd_valid <= 1'b0;
            word_busy <= 1'b0;
            irq_accept <= 1'b0;
        end
        else
        begin
            word_rd_valid <= 1'b0;
            irq_accept <= 1'b0;
            word_busy <= (seq_next != CSB_SEQ_IDLE);
            case (seq_reg)
                CSB_SEQ_IDLE:
                begin
                    if (word_wr_req)
                    begin
                        mem_addr <= word_addr;
                        mem_wdata <= word_wdata[15:8];
                        seq_lo_reg <= word_wdata[7:0];
                        mem_we <= 1'b1;
                    end
                    else if (irq_take)
                    begin
                        mem_addr <= push_base;
                        mem_wdata <= psw_rd_data[15:8];
                        seq_lo_reg <= psw_rd_data[7:0];
                        mem_we <= 1'b1;
                        irq_accept <= 1'b1;
                    end
                    else if (word_rd_req)
                    begin
                        mem_addr <= word_addr;
                        mem_re <= 1'b1;
                    end
                end
                CSB_SEQ_WR_HI:
                begin
                    mem_addr <= mem_addr + `CSB_WORD_STEP;
                    mem_wdata <= seq_lo_reg;
                end
                CSB_SEQ_WR_LO:
                begin
                    mem_we <= 1'b0;
                end
                CSB_SEQ_RD_HI:
                begin
                    seq_addr_reg <= mem_addr;
                    mem_addr <= mem_addr + `CSB_WORD_STEP;
                end
                CSB_SEQ_RD_LO:
                begin
                    mem_re <= 1'b0;
                    rd_hi_reg <= mem_rdata;
                end
                CSB_SEQ_RD_DONE:
                begin
                    word_rdata <= {rd_hi_reg, mem_rdata};
                    word_rd_valid <= 1'b1;
                end
                default:
                begin
                    mem_we <= 1'b0;
                    mem_re <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // instruction operand assembly, first byte is the high byte
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            opnd_hi_seen_reg <= 1'b0;
            opnd_hi_reg <= 8'h00;
            opnd_word <= 16'h0000;
            opnd_word_valid <= 1'b0;
        end
        else
        begin
            opnd_word_valid <= 1'b0;
            if (opnd_valid)
            begin
                if (!opnd_hi_seen_reg)
                    opnd_hi_reg <= opnd_byte;
                else
                begin
                    opnd_word <= {opnd_hi_reg, opnd_byte};
                    opnd_word_valid <= 1'b1;
                end
                opnd_hi_seen_reg <= !opnd_hi_seen_reg;
            end
        end
    end

endmodule
`default_nettype wire

// ===== csb_status_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module csb_status_monitor
(
    input wire logic clk, // machine clock
    input wire logic rst_n, // reset, low
    input wire logic psw_wr_en, // word write
    input wire logic [15:0] psw_wr_data, // word data
    input wire logic [15:0] psw_rd_data, // word readback
    input wire logic mirror_wr_en, // mirror write
    input wire logic [7:0] mirror_wr_data, // mirror data
    input wire logic flag_upd_en, // flag load
    input wire logic [7:0] alu_result_q, // result
    input wire logic irq_req, // request
    input wire logic [1:0] irq_level, // request level
    input wire logic [15:0] sp_in, // stack pointer
    input wire logic irq_accept, // accept pulse
    input wire logic [7:0] dir_operand, // direct operand
    input wire logic [2:0] reg_sel, // register index
    input wire logic [15:0] dir_addr_q, // direct address
    input wire logic [15:0] gpr_addr_q, // register address
    input wire logic word_wr_req, // word write
    input wire logic word_rd_req, // word read
    input wire logic word_rd_valid, // read done
    input wire logic word_busy, // busy
    input wire logic [15:0] mem_addr, // byte address
    input wire logic [7:0] mem_wdata, // byte data
    input wire logic mem_we // byte write
);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic [1:0] live_reg;

    // counts edges since reset so that past values are meaningful
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            live_reg <= 2'h0;
        else if (live_reg != 2'h3)
            live_reg <= live_reg + 2'h1;
    end

    // ****************************************************************
    // status word, mapping and sequencing checks
    // ****************************************************************
    a_psw_write_lands:
    assert property (psw_wr_en |=> psw_rd_data == $past(psw_wr_data))
        else $error("status word write lost");
    a_mirror_keeps_level:
    assert property ((mirror_wr_en && !psw_wr_en) ##1 !irq_accept |->
        psw_rd_data[15:8] == $past(mirror_wr_data) &&
        psw_rd_data[5:4] == $past(psw_rd_data[5:4]))
        else $error("mirror write disturbed level bits");
    a_direct_map:
    assert property (live_reg == 2'h3 |-> dir_addr_q ==
        ($past(dir_operand[7]) ? 16'h0080 +
        {6'h00, $past(psw_rd_data[10:8]), 7'h00} +
        {9'h000, $past(dir_operand[6:0])} : {8'h00, $past(dir_operand)}))
        else $error("direct address wrong");
    a_bank_map:
    assert property (live_reg == 2'h3 |-> gpr_addr_q == 16'h0100 +
        {8'h00, $past(psw_rd_data[15:11]), 3'h0} +
        {13'h0000, $past(reg_sel)})
        else $error("register address wrong");
    a_result_nz_flags:
    assert property (flag_upd_en && !psw_wr_en |=>
        psw_rd_data[3] == alu_result_q[7] &&
        psw_rd_data[2] == (alu_result_q == 8'h00))
        else $error("negative or zero flag wrong");
    a_irq_gate:
    assert property (irq_accept |-> $past(irq_req) &&
        $past(psw_rd_data[6]) && $past(irq_level) < $past(psw_rd_data[5:4])
        && psw_rd_data[5:4] == $past(irq_level))
        else $error("interrupt accepted wrongly");
    a_push_order:
    assert property (irq_accept |-> mem_we &&
        mem_addr == $past(sp_in) - 16'h0002 &&
        mem_wdata == $past(psw_rd_data[15:8]) ##1 mem_we &&
        mem_addr == $past(sp_in, 2) - 16'h0001 &&
        mem_wdata == $past(psw_rd_data[7:0], 2))
        else $error("status push order wrong");
    a_read_done:
    assert property (word_rd_req && !word_busy && !word_wr_req |->
        ##[3:6] word_rd_valid)
        else $error("word read never finished");

endmodule

bind csb_status_core csb_status_monitor u_mon
(
    .clk, .rst_n, .psw_wr_en, .psw_wr_data, .psw_rd_data, .mirror_wr_en,
    .mirror_wr_data, .flag_upd_en, .alu_result_q, .irq_req, .irq_level,
    .sp_in, .irq_accept, .dir_operand, .reg_sel, .dir_addr_q, .gpr_addr_q,
    .word_wr_req, .word_rd_req, .word_rd_valid, .word_busy, .mem_addr,
    .mem_wdata, .mem_we
);

`default_nettype wire

// ===== csb_ram_model.sv
`timescale 1ns/1ns
`default_nettype none

module csb_ram_model
(
    input wire logic clk, // machine clock
    input wire logic [15:0] mem_addr, // byte address
    input wire logic [7:0] mem_wdata, // write byte
    input wire logic mem_we, // write strobe
    input wire logic mem_re, // read strobe
    output logic [7:0] mem_rdata // read byte, next cycle
);

    logic [7:0] mem [0:65535];

    initial
    begin
        mem_rdata = 8'h5a;
    end

    // one byte per edge; data not asked for toggles so stale reads show
    always @(posedge clk)
    begin
        if (mem_we)
            mem[mem_addr] <= mem_wdata;
        if (mem_re)
            mem_rdata <= mem[mem_addr];
        else
            mem_rdata <= ~mem_rdata;
    end

endmodule

`default_nettype wire

// ===== tb_cpu_status_and_bank_mapping.sv
`timescale 1ns/1ns
`default_nettype none

module tb_cpu_status_and_bank_mapping
    import csb_pkg::*;
;
    logic clk, rst_n, psw_wr_en, mirror_wr_en, flag_upd_en, alu_cin;
    logic ie_set, ie_clr, irq_req, irq_accept, word_wr_req, word_rd_req;
    logic word_rd_valid, word_busy, mem_we, mem_re, opnd_valid;
    logic opnd_word_valid;
    logic [1:0] irq_level;
    logic [2:0] reg_sel;
    logic [7:0] mirror_wr_data, mirror_rd_data, alu_a, alu_b, alu_result_q;
    logic [7:0] dir_operand, mem_wdata, mem_rdata, opnd_byte;
    logic [15:0] psw_wr_data, psw_rd_data, sp_in, dir_addr_q, gpr_addr_q;
    logic [15:0] word_addr, word_wdata, word_rdata, mem_addr, opnd_word;
    csb_alu_op_type alu_op;
    int bad_count, comparisons;
    // {op, a, b, result, flags h n z v c}
    logic [35:0] vec [10] = '{36'h0_01_01_02_00, 36'h0_08_08_10_10,
        36'h0_7f_01_80_1a, 36'h0_ff_01_00_15, 36'h1_00_01_ff_19,
        36'h1_80_01_7f_12, 36'h2_81_00_02_11, 36'h3_01_00_00_15,
        36'h4_00_00_00_15, 36'h1_13_02_11_00};

    csb_status_core dut
    (
        .clk, .rst_n, .psw_wr_en, .psw_wr_data, .psw_rd_data, .mirror_wr_en,
        .mirror_wr_data, .mirror_rd_data, .flag_upd_en, .alu_op, .alu_a,
        .alu_b, .alu_cin, .alu_result_q, .ie_set, .ie_clr, .irq_req,
        .irq_level, .sp_in, .irq_accept, .dir_operand, .reg_sel, .dir_addr_q,
        .gpr_addr_q, .word_wr_req, .word_rd_req, .word_addr, .word_wdata,
        .word_rdata, .word_rd_valid, .word_busy, .mem_addr, .mem_wdata,
        .mem_we, .mem_re, .mem_rdata, .opnd_valid, .opnd_byte, .opnd_word,
        .opnd_word_valid
    );

    csb_ram_model ram
    (
        .clk, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata
    );

    // machine clock, 20 ns period
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic tick;
        @(negedge clk);
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        tick();
        sig = 1'b0;
        tick();
    endtask

    task automatic irq_try(input logic [1:0] lvl, input logic exp);
        logic seen;
        seen = 1'b0;
        irq_level = lvl;
        irq_req = 1'b1;
        repeat (4)
        begin
            tick();
            seen = seen | (irq_accept === 1'b1);
        end
        irq_req = 1'b0;
        repeat (3) tick();
        chk({15'h0000, seen}, {15'h0000, exp});
    endtask

    task automatic word_op(input logic rd, input logic [15:0] a,
                           input logic [15:0] d);
        word_addr = a;
        word_wdata = d;
        if (rd)
            pulse(word_rd_req);
        else
            pulse(word_wr_req);
        for (int i = 0; i < 8 && word_busy !== 1'b0; i++)
            tick();
        tick();
        if (rd)
            chk(word_rdata, d);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // cuts a hung run short
    initial
    begin
        repeat (3000) @(posedge clk);
        bad_count++;
        results();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial
    begin
        {rst_n, psw_wr_en, mirror_wr_en, flag_upd_en, alu_cin} = 5'h00;
        {ie_set, ie_clr, irq_req, word_wr_req, word_rd_req} = 5'h00;
        {opnd_valid, irq_level, reg_sel} = 6'h00;
        {mirror_wr_data, alu_a, alu_b, dir_operand, opnd_byte} = 40'h0;
        {psw_wr_data, sp_in, word_addr, word_wdata} = 64'h0;
        alu_op = CSB_OP_ADD;
        bad_count = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        tick();
        rst_n = 1'b1;
        tick();
        chk(psw_rd_data, 16'h0030);
        chk({8'h00, mirror_rd_data}, 16'h0000);
        psw_wr_data = 16'ha5c3;
        pulse(psw_wr_en);
        chk(psw_rd_data, 16'ha5c3);
        chk({8'h00, mirror_rd_data}, 16'h00a5);
        psw_wr_data = 16'h0020;
        pulse(psw_wr_en);
        mirror_wr_data = 8'h5b;
        pulse(mirror_wr_en);
        chk(psw_rd_data, 16'h5b20);
        $display("test status_word finished");
        for (int i = 0; i < 8; i++)
        begin
            mirror_wr_data = {i[2:0], 2'b11, i[2:0]};
            pulse(mirror_wr_en);
            for (int j = 0; j < 4; j++)
            begin
                dir_operand = {j[1], {7{j[0]}}};
                reg_sel = i[2:0];
                tick();
                chk(dir_addr_q, j[1] ? 16'h0080 + 16'(i) * 16'h0080 +
                    {9'h000, {7{j[0]}}} : {8'h00, dir_operand});
                chk(gpr_addr_q, 16'h0100 + {8'h00, i[2:0], 2'b11, 3'h0} +
                    {13'h0000, i[2:0]});
            end
        end
        $display("test mapping finished");
        psw_wr_data = 16'h0030;
        pulse(psw_wr_en);
        for (int k = 0; k < 10; k++)
        begin
            alu_op = csb_alu_op_type'(vec[k][34:32]);
            alu_a = vec[k][31:24];
            alu_b = vec[k][23:16];
            pulse(flag_upd_en);
            chk({psw_rd_data[7:0], alu_result_q}, {vec[k][4], 3'b011,
                vec[k][3:0], vec[k][15:8]});
        end
        $display("test flags finished");
        psw_wr_data = 16'h4330;
        pulse(psw_wr_en);
        sp_in = 16'h0200;
        irq_try(2'b01, 1'b0);
        pulse(ie_set);
        chk(psw_rd_data, 16'h4370);
        irq_try(2'b11, 1'b0);
        irq_try(2'b10, 1'b1);
        chk(psw_rd_data, 16'h4360);
        chk({ram.mem[16'h01fe], ram.mem[16'h01ff]}, 16'h4370);
        irq_try(2'b10, 1'b0);
        irq_try(2'b01, 1'b1);
        chk(psw_rd_data, 16'h4350);
        pulse(ie_clr);
        chk(psw_rd_data, 16'h4310);
        $display("test interrupts finished");
        word_op(1'b0, 16'h0300, 16'hbeef);
        chk({ram.mem[16'h0300], ram.mem[16'h0301]}, 16'hbeef);
        word_op(1'b1, 16'h01fe, 16'h4360);
        word_op(1'b1, 16'h0300, 16'hbeef);
        opnd_byte = 8'h12;
        pulse(opnd_valid);
        opnd_byte = 8'h34;
        opnd_valid = 1'b1;
        tick();
        chk({15'h0000, opnd_word_valid}, 16'h0001);
        chk(opnd_word, 16'h1234);
        $display("test words finished");
        results();
    end

endmodule

`default_nettype wire
